// ### shared/cfg_pkg.sv
// Constants shared by the configuration shadow loader
// How it works
// RULE1 - reset copies flash configuration words into shadows
// RULE2 - copy repeats on every reset source
// RULE3 - shadows are volatile, refilled after power-up
// RULE4 - words fetched from top of program memory
// RULE5 - software programs upper word bits as ones
// RULE6 - unimplemented bits have no configuration effect
// RULE7 - erased configuration words enable code protection
// RULE8 - processor held in reset until load completes
`default_nettype none
package cfg_pkg;

	// ----------------------------------------------------------------
	// Flash side layout
	// ----------------------------------------------------------------
	localparam int              NUM_WORDS  = 5;
	localparam int              NUM_SIZES  = 4;
	localparam logic [2:0]      LAST_WORD  = 3'h4;
	localparam logic [3:0][23:0] SEC_BASE  = {24'h02AB80, 24'h015780, 24'h00AB80, 24'h005780};
	localparam logic [4:0][7:0] WORD_OFF   = {8'h1C, 8'h18, 8'h14, 8'h10, 8'h00};
	localparam logic [4:0][15:0] IMPL_MASK = {16'h01E7, 16'h0087, 16'h8000, 16'h1FFF, 16'h8FEF};
	localparam logic [7:0]      UPPER_FILL = 8'hFF;

	// ----------------------------------------------------------------
	// Field positions inside the security word
	// ----------------------------------------------------------------
	localparam int              SEC_BSS_LSB = 1;
	localparam int              SEC_GSS_LSB = 6;
	localparam int              SEC_CSS_LSB = 9;

	// ----------------------------------------------------------------
	// APB register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int              ADDR_W       = 16;
	localparam logic [15:0]     REG_STATUS   = 16'h5700;
	localparam logic [15:0]     REG_CONTROL  = 16'h5704;
	localparam logic [15:0]     REG_SECURITY = 16'h5780;
	localparam logic [15:0]     REG_BOOT_LIMIT = 16'h5790;
	localparam logic [15:0]     REG_RSVD     = 16'h5794;
	localparam logic [15:0]     REG_OSCSEL   = 16'h5798;
	localparam logic [15:0]     REG_OSC      = 16'h579C;
	localparam int              STAT_LOADED  = 0;
	localparam int              STAT_SIZE    = 1;
	localparam int              CTRL_RELOAD  = 0;

	typedef enum logic [1:0] {
		LD_FETCH = 2'b00,
		LD_WAIT  = 2'b01,
		LD_DONE  = 2'b11
	} load_e;

endpackage : cfg_pkg
`default_nettype wire

// ### shared/fetch_if.sv
// Word fetch handshake between the loader and its flash reader
`timescale 1ns/10ps
`default_nettype none
interface fetch_if;
	logic        req;
	logic [23:0] addr;
	logic        ack;
	logic [23:0] data;

	modport loader (output req, output addr, input ack, input data);
	modport reader (input req, input addr, output ack, output data);
endinterface : fetch_if
`default_nettype wire

// ### rtl/flash_word_reader.sv
// Single-word reader for the program flash read port
`timescale 1ns/10ps
`default_nettype none
module flash_word_reader (
	input  wire logic    clk,
	input  wire logic    rstn,
	fetch_if.reader      fetch,
	output logic         flash_rd,
	output logic [23:0]  flash_addr,
	input  wire logic [23:0] flash_rdata,
	input  wire logic    flash_valid
);
	import cfg_pkg::*;

	typedef struct packed {
		logic        busy;
		logic [23:0] addr;
		logic [23:0] data;
		logic        ack;
	} rd_s;

	rd_s st;
	rd_s next_st;

	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		if (!st.busy && fetch.req) begin
			next_st.busy = 1'b1;
			next_st.addr = fetch.addr;
		end else if (st.busy && flash_valid) begin
			next_st.busy = 1'b0;
			next_st.data = flash_rdata;
			next_st.ack  = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Request held until the flash answers, however slow it is
	assign flash_rd   = st.busy;
	assign flash_addr = st.addr;
	assign fetch.ack  = st.ack;
	assign fetch.data = st.data;

	addr_stable_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE4]
		flash_rd && !flash_valid |=> $stable(flash_addr) && flash_rd)
		else $error("flash address moved during a pending read");

endmodule : flash_word_reader
`default_nettype wire

// ### rtl/cfg_shadow_loader.sv
// Configuration shadow loader with APB readback
`timescale 1ns/10ps
`default_nettype none
module cfg_shadow_loader #(
	parameter int MEM_SIZE_SEL = 0
) (
	input  wire logic                      SYS_CLK,
	input  wire logic                      RSTN,
	input  wire logic                      PSEL,
	input  wire logic                      PENABLE,
	input  wire logic                      PWRITE,
	input  wire logic [cfg_pkg::ADDR_W-1:0] PADDR,
	input  wire logic [31:0]               PWDATA,
	output logic [31:0]                    PRDATA,
	output logic                           PREADY,
	output logic                           PSLVERR,
	output logic                           FLASH_RD,
	output logic [23:0]                    FLASH_ADDR,
	input  wire logic [23:0]               FLASH_RDATA,
	input  wire logic                      FLASH_VALID,
	output logic                           CPU_RESET_N,
	output logic [79:0]                    CFG_SHADOW,
	output logic                           GENERAL_SEG_PROTECT,
	output logic                           BOOT_SEG_PROTECT,
	output logic                           CONFIG_SEG_PROTECT
);
	import cfg_pkg::*;

	if (MEM_SIZE_SEL < 0 || MEM_SIZE_SEL >= NUM_SIZES) begin : g_bad_size
		$error("MEM_SIZE_SEL must select one of four memory sizes");
	end

	localparam logic [1:0]  SIZE_CODE = 2'(MEM_SIZE_SEL);
	localparam logic [23:0] BASE      = SEC_BASE[SIZE_CODE];

	typedef struct packed {
		load_e             phase;
		logic [2:0]        idx;
		logic              loaded;
		logic [4:0][15:0]  shadow;
		logic [31:0]       prdata;
		logic              slverr;
	} top_s;

	top_s    st;
	top_s    next_st;
	fetch_if fetch ();

	logic        setup;
	logic        access;
	logic        hit;
	logic [31:0] rd_val;
	logic [4:0][31:0] word_view;

	// ----------------------------------------------------------------
	// Readback view of each shadow word
	// ----------------------------------------------------------------
	genvar gi;
	for (gi = 0; gi < NUM_WORDS; gi++) begin : g_view
		// Unimplemented positions read back as ones and steer nothing
		assign word_view[gi] = {8'h00, UPPER_FILL, st.shadow[gi] | ~IMPL_MASK[gi]}; // [RULE6]
	end

	assign setup  = PSEL && !PENABLE;
	assign access = PSEL && PENABLE;

	always_comb begin
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		case (PADDR)
			REG_STATUS: begin
				rd_val[STAT_LOADED]            = st.loaded;
				rd_val[STAT_SIZE +: 2]         = SIZE_CODE;
			end
			REG_CONTROL:  rd_val = 32'h0000_0000;
			REG_SECURITY: rd_val = word_view[0];
			REG_BOOT_LIMIT: rd_val = word_view[1];
			REG_RSVD:     rd_val = word_view[2];
			REG_OSCSEL:   rd_val = word_view[3];
			REG_OSC:      rd_val = word_view[4];
			default:      hit    = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Load sequencer and bus slave
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (setup) begin
			next_st.prdata = PWRITE ? 32'h0000_0000 : rd_val;
			next_st.slverr = !hit;
		end
		case (st.phase)
			LD_FETCH: begin
				next_st.phase = LD_WAIT;
			end
			LD_WAIT: begin
				if (fetch.ack) begin
					// Upper byte from flash is dropped: it carries no settings
					next_st.shadow[st.idx] = fetch.data[15:0] & IMPL_MASK[st.idx]; // [RULE1] [RULE6]
					if (st.idx == LAST_WORD) begin
						next_st.phase  = LD_DONE;
						next_st.loaded = 1'b1; // [RULE8]
					end else begin
						next_st.idx   = st.idx + 3'h1;
						next_st.phase = LD_FETCH;
					end
				end
			end
			LD_DONE: begin
				// Software reload behaves like another reset source
				if (access && PWRITE && PADDR == REG_CONTROL && PWDATA[CTRL_RELOAD]) begin
					next_st.phase  = LD_FETCH; // [RULE2]
					next_st.idx    = 3'h0;
					next_st.loaded = 1'b0;
				end
			end
			default: begin
				next_st.phase = LD_FETCH;
				next_st.idx   = 3'h0;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			st <= '0; // [RULE2] [RULE3]
		end else begin
			st <= next_st;
		end
	end

	assign fetch.req  = (st.phase == LD_FETCH);
	assign fetch.addr = BASE + {16'h0000, WORD_OFF[st.idx]}; // [RULE4]

	flash_word_reader u_reader (
		.clk         (SYS_CLK),
		.rstn        (RSTN),
		.fetch       (fetch),
		.flash_rd    (FLASH_RD),
		.flash_addr  (FLASH_ADDR),
		.flash_rdata (FLASH_RDATA),
		.flash_valid (FLASH_VALID)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PRDATA      = st.prdata;
	assign PREADY      = 1'b1;
	assign PSLVERR     = access && st.slverr;
	assign CPU_RESET_N = st.loaded; // [RULE8]
	assign CFG_SHADOW  = st.shadow;
	// Erased (all zero) security fields turn protection on
	assign GENERAL_SEG_PROTECT = st.loaded && (st.shadow[0][SEC_GSS_LSB +: 2] != 2'b11); // [RULE7]
	assign BOOT_SEG_PROTECT    = st.loaded && (st.shadow[0][SEC_BSS_LSB +: 2] != 2'b11); // [RULE7]
	assign CONFIG_SEG_PROTECT  = st.loaded && (st.shadow[0][SEC_CSS_LSB +: 3] != 3'b111); // [RULE7]

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	cpu_held_reset_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [RULE8]
		$rose(CPU_RESET_N) |-> $past(fetch.ack) && $past(st.idx) == LAST_WORD)
		else $error("processor released before last word captured");

	reset_reload_a: assert property (@(posedge SYS_CLK) // [RULE2]
		!RSTN |=> !CPU_RESET_N && FLASH_ADDR == 24'h000000 && st.idx == 3'h0)
		else $error("reset did not restart the load");

	volatile_clear_a: assert property (@(posedge SYS_CLK) // [RULE3]
		!RSTN |=> CFG_SHADOW == 80'h0 && !GENERAL_SEG_PROTECT)
		else $error("shadow contents survived reset");

	fetch_address_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [RULE4]
		$rose(FLASH_RD) |-> FLASH_ADDR[23:8] == BASE[23:8])
		else $error("configuration fetched outside the top region");

	upper_bits_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [RULE6]
		fetch.ack |=> (st.shadow[$past(st.idx)] & ~IMPL_MASK[$past(st.idx)]) == 16'h0000)
		else $error("unimplemented bit reached a shadow register");

	erase_protect_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [RULE7]
		CPU_RESET_N && st.shadow[0] == 16'h0000 |-> GENERAL_SEG_PROTECT && BOOT_SEG_PROTECT)
		else $error("erased security word left code unprotected");

	word_captured_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [RULE1]
		fetch.ack && st.phase == LD_WAIT |=>
			st.shadow[$past(st.idx)] == ($past(fetch.data[15:0]) & IMPL_MASK[$past(st.idx)]))
		else $error("fetched word not copied to its shadow");

	load_sequence_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [RULE1]
		fetch.ack && st.idx != LAST_WORD |=> st.phase == LD_FETCH ##1 FLASH_RD)
		else $error("load sequence stalled between words");

	unmapped_err_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		setup && !hit |=> PSLVERR || !access)
		else $error("unmapped access not flagged");

	protect_after_load_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [RULE7]
		!CPU_RESET_N |-> !GENERAL_SEG_PROTECT && !BOOT_SEG_PROTECT && !CONFIG_SEG_PROTECT)
		else $error("protection shown before the load finished");

	// Bus writes and reload requests must never disturb a shadow
	shadow_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [RULE1]
		!fetch.ack |=> $stable(CFG_SHADOW))
		else $error("shadow changed without a flash answer");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	load_done_c: cover property (@(posedge SYS_CLK) disable iff (!RSTN) $rose(CPU_RESET_N));
	sw_reload_c: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
		CPU_RESET_N ##1 !CPU_RESET_N);
	status_read_c: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
		access && !PWRITE && PADDR == REG_STATUS && CPU_RESET_N);
	mid_load_reset_c: cover property (@(posedge SYS_CLK) FLASH_RD ##1 !RSTN);
	erased_load_c: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
		$rose(CPU_RESET_N) && CFG_SHADOW == 80'h0);

endmodule : cfg_shadow_loader
`default_nettype wire

// ### testbench/flash_model.sv
// Behavioural program flash answering single-word reads
`timescale 1ns/10ps
`default_nettype none
module flash_model #(
	parameter logic [23:0] BASE = 24'h00AB80
) (
	input  wire logic             clk,
	input  wire logic [4:0][23:0] image,
	input  wire logic             slow,
	input  wire logic             rd,
	input  wire logic [23:0]      addr,
	output logic                  valid,
	output logic [23:0]           rdata,
	output logic                  addr_err
);
	logic [23:0] off;
	logic [2:0]  idx;
	int          wait_n;
	assign off = addr - BASE;
	assign idx = (off == 24'h0) ? 3'h0 : {1'b0, off[3:2]} + 3'h1;
	initial begin
		valid = 1'b0;
		rdata = 24'h0;
		addr_err = 1'b0;
		wait_n = 0;
	end
	always @(posedge clk) begin
		if (rd && !valid && wait_n >= (slow ? 3 : 0)) begin
			valid <= 1'b1;
			rdata <= image[idx];
			if (!(off == 24'h0 || (off[23:5] == 19'h0 && off[4] && off[1:0] == 2'h0))) begin
				addr_err <= 1'b1;
			end
		end else begin
			valid <= 1'b0;
			// Released bus flips, so a stale word is never read as good
			rdata <= ~rdata;
		end
		wait_n <= (rd && !valid) ? wait_n + 1 : 0;
	end
endmodule : flash_model
`default_nettype wire

// ### testbench/config_word_shadow_loader_tb_top.sv
// Self-checking bench for the configuration shadow loader
`timescale 1ns/10ps
`default_nettype none
module config_word_shadow_loader_tb_top;
	import cfg_pkg::*;
	localparam int SIZE = 1;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, frd, fvalid, cpu_rstn, gp, bp, cp, er, aerr, slow = 1'b0;
	logic [23:0] faddr, frdata;
	logic [79:0] shadow;
	logic [4:0][23:0] image = '0;
	logic [4:0][15:0] regs = {REG_OSC, REG_OSCSEL, REG_RSVD, REG_BOOT_LIMIT, REG_SECURITY};
	int checks = 0, mismatches = 0, cyc = 0, seed = 32'h970d8e34;
	always #20 clk = ~clk;
	cfg_shadow_loader #(.MEM_SIZE_SEL(SIZE)) cfg_shadow_loader_i (.SYS_CLK(clk),
		.RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.FLASH_RD(frd), .FLASH_ADDR(faddr), .FLASH_RDATA(frdata), .FLASH_VALID(fvalid),
		.CPU_RESET_N(cpu_rstn), .CFG_SHADOW(shadow), .GENERAL_SEG_PROTECT(gp),
		.BOOT_SEG_PROTECT(bp), .CONFIG_SEG_PROTECT(cp));
	flash_model #(.BASE(SEC_BASE[SIZE])) flash_model_i (.clk(clk), .image(image),
		.slow(slow), .rd(frd), .addr(faddr), .valid(fvalid), .rdata(frdata),
		.addr_err(aerr));
	task chk(input logic [80:0] g, input logic [80:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task new_image(input logic [7:0] up);
		for (int i = 0; i < 5; i++) begin
			image[i] <= {up, 16'($random(seed))};
		end
	endtask : new_image
	task do_reset();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		chk({cpu_rstn, shadow}, 81'h0);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		chk(cpu_rstn, 1'b0);
	endtask : do_reset
	task check_all();
		logic [79:0] e;
		int n;
		n = 0;
		for (int i = 0; i < 5; i++) e[i*16+:16] = image[i][15:0] & IMPL_MASK[i];
		while (cpu_rstn !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk(cpu_rstn, 1'b1);
		chk(shadow, e);
		chk({gp, bp, cp}, {~&e[7:6], ~&e[2:1], ~&e[11:9]});
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, regs[i], 32'h0);
			chk({er, r}, {9'h0FF, e[i*16+:16] | ~IMPL_MASK[i]});
		end
		apb(1'b0, REG_STATUS, 32'h0);
		chk(r, {29'h0, 2'(SIZE), 1'b1});
		chk(aerr, 1'b0);
	endtask : check_all
	task reload();
		apb(1'b1, REG_CONTROL, 32'h1);
		repeat (2) @(posedge clk);
		chk(cpu_rstn, 1'b0);
		check_all();
	endtask : reload
	task print_verdict();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		new_image(8'hFF);
		do_reset();
		check_all();
		$display("test power-up load done");
		slow <= 1'b1;
		do_reset();
		repeat (8) @(posedge clk);
		new_image(8'hFF);
		do_reset();
		check_all();
		$display("test reset mid-load done");
		new_image(8'h00);
		reload();
		apb(1'b0, 16'h5710, 32'h0);
		chk({er, r}, {1'b1, 32'h0});
		apb(1'b1, REG_SECURITY, 32'($random(seed)));
		check_all();
		$display("test reload and refusals done");
		slow <= 1'b0;
		image <= '0;
		reload();
		$display("test erased words done");
		print_verdict();
	end
endmodule : config_word_shadow_loader_tb_top
`default_nettype wire
